// *** rtl/osc_cfg_top.sv ***
// Oscillator source configuration: power-on decode of the clock fields,
// start-up timing, PLL lock mirror, oscillator pin roles, AXI4-Lite regs.
// Assumes config words come from nonvolatile storage on clk.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "osc_params.svh"

module osc_cfg_top (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Nonvolatile configuration words
    input  wire logic [23:0] cfgSelWord,
    input  wire logic [23:0] cfgModeWord,
    // Wake-up from sleep
    input  wire logic        wakeEvent,
    // First oscillator pin and PLL lock
    input  wire logic        oscInPinI,
    input  wire logic        pllLockRaw,
    // Second oscillator pin
    input  wire logic        oscOutPinI,
    output logic             oscOutPinO,
    output logic             oscOutPinOe,
    // General I/O path for second pin
    input  wire logic        gpioOut,
    input  wire logic        gpioOe,
    output logic             gpioIn,
    // Oscillator and PLL control
    output logic [3:0]       clkSel,
    output logic             feedbackEn,
    output logic             oscInHiZ,
    output logic             pllEnable,
    output logic [5:0]       pllMult,
    output logic             pllRangeHigh,
    output logic             frcRangeHigh,
    output logic [15:0]      frcNominalKhz,
    output logic             clkSwitchEn,
    output logic             failMonEn,
    output logic             oscReady,
    output logic             pllLock
);

    // ************************************************************
    // Declarations
    // ************************************************************
    osc_pkg::osc_state_e state_r;
    osc_pkg::osc_state_e state_nxt;
    osc_pkg::osc_src_e   src_r;
    osc_pkg::osc_src_e   src_nxt;

    logic [23:0] selCfg_r;
    logic [23:0] modeCfg_r;
    logic [2:0]  syncIn;
    logic        oscInSync;
    logic        oscOutSync;
    logic        lockSync;
    logic        oscPrev_r;
    logic        oscRise;
    logic        ostStart;
    logic        ostRunning;
    logic        ostDone;
    logic [9:0]  ostCount;
    logic        sleepReq_r;
    logic        divToggle_r;
    logic [1:0]  grpSel;
    logic [1:0]  priSel;
    logic        priValid;
    logic        usePri;
    logic        usePll;
    logic        xtalActive;
    logic        drvClk;
    logic        awHeld_r;
    logic [7:0]  awAddr_r;
    logic        wHeld_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        doWrite;
    logic        arTake;
    logic [31:0] rdNxt;
    logic [1:0]  rrNxt;
    logic [31:0] statWord;

    // ************************************************************
    // Input synchronisers and oscillator edge
    // ************************************************************
    osc_sync2 u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .asyncIn ({pllLockRaw, oscOutPinI, oscInPinI}),
        .syncOut (syncIn)
    );

    assign oscInSync  = syncIn[0];
    assign oscOutSync = syncIn[1];
    assign lockSync   = syncIn[2];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscPrev_r <= 1'b0;
        end else if (ce) begin
            oscPrev_r <= oscInSync;
        end
    end

    assign oscRise = oscInSync & ~oscPrev_r;

    // ************************************************************
    // Configuration capture
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            selCfg_r  <= `OSC_CFG_RESET;
            modeCfg_r <= `OSC_CFG_RESET;
        end else if (ce && state_r == osc_pkg::OSC_ST_POR) begin
            selCfg_r  <= cfgSelWord & `OSC_SEL_MASK;
            modeCfg_r <= cfgModeWord & `OSC_MODE_MASK;
        end
    end

    // ************************************************************
    // Field decode
    // ************************************************************
    assign grpSel   = selCfg_r[`OSC_GRP_LSB +: 2];
    assign priSel   = modeCfg_r[`OSC_PRI_LSB +: 2];
    assign priValid = (priSel == `OSC_PRI_XTAL) ||
                      (priSel == `OSC_PRI_EXT);

    always_comb begin
        case (grpSel)
            2'h0:    src_nxt = osc_pkg::OSC_SRC_FRC;
            2'h1:    src_nxt = osc_pkg::OSC_SRC_FRC_PLL;
            2'h2:    src_nxt = priValid ? osc_pkg::OSC_SRC_PRI
                                        : osc_pkg::OSC_SRC_FRC;
            2'h3:    src_nxt = priValid ? osc_pkg::OSC_SRC_PRI_PLL
                                        : osc_pkg::OSC_SRC_FRC_PLL;
            default: src_nxt = osc_pkg::OSC_SRC_FRC;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_r <= osc_pkg::OSC_SRC_FRC;
        end else if (ce && state_r == osc_pkg::OSC_ST_START) begin
            src_r <= src_nxt;
        end
    end

    assign usePri = (src_r == osc_pkg::OSC_SRC_PRI) ||
                    (src_r == osc_pkg::OSC_SRC_PRI_PLL);
    assign usePll = (src_r == osc_pkg::OSC_SRC_FRC_PLL) ||
                    (src_r == osc_pkg::OSC_SRC_PRI_PLL);

    // ************************************************************
    // Start-up sequencer
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        ostStart  = 1'b0;
        case (state_r)
            osc_pkg::OSC_ST_POR: begin
                state_nxt = osc_pkg::OSC_ST_START;
            end
            osc_pkg::OSC_ST_START: begin
                if (grpSel[1] && priSel == `OSC_PRI_XTAL) begin
                    ostStart  = 1'b1;
                    state_nxt = osc_pkg::OSC_ST_OST;
                end else begin
                    state_nxt = osc_pkg::OSC_ST_RUN;
                end
            end
            osc_pkg::OSC_ST_OST: begin
                if (ostDone) begin
                    state_nxt = osc_pkg::OSC_ST_RUN;
                end else if (sleepReq_r) begin
                    state_nxt = osc_pkg::OSC_ST_SLEEP;
                end
            end
            osc_pkg::OSC_ST_RUN: begin
                if (sleepReq_r) begin
                    state_nxt = osc_pkg::OSC_ST_SLEEP;
                end
            end
            osc_pkg::OSC_ST_SLEEP: begin
                if (!sleepReq_r) begin
                    state_nxt = osc_pkg::OSC_ST_START;
                end
            end
            default: state_nxt = osc_pkg::OSC_ST_POR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= osc_pkg::OSC_ST_POR;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    osc_startup_timer u_ost (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .start   (ostStart),
        .oscRise (oscRise),
        .running (ostRunning),
        .done    (ostDone),
        .count   (ostCount)
    );

    // ************************************************************
    // Oscillator, PLL and range outputs
    // ************************************************************
    assign xtalActive = usePri && priSel == `OSC_PRI_XTAL &&
                        state_r != osc_pkg::OSC_ST_SLEEP;
    assign clkSel     = src_r;
    assign feedbackEn = xtalActive;
    assign oscInHiZ   = ~xtalActive;
    assign oscReady   = state_r == osc_pkg::OSC_ST_RUN;
    assign pllEnable  = usePll && state_r == osc_pkg::OSC_ST_RUN;
    assign pllMult    = `OSC_PLL_MULT;
    assign pllLock    = lockSync & pllEnable;
    assign frcRangeHigh  = modeCfg_r[`OSC_RANGE_BIT];
    assign pllRangeHigh  = modeCfg_r[`OSC_RANGE_BIT];
    assign frcNominalKhz = modeCfg_r[`OSC_RANGE_BIT] ? `OSC_FRC_HI_KHZ
                                                     : `OSC_FRC_LO_KHZ;
    assign clkSwitchEn = ~modeCfg_r[`OSC_SWMON_LSB + 1];
    assign failMonEn   = modeCfg_r[`OSC_SWMON_LSB +: 2] == 2'h0;

    // ************************************************************
    // Second oscillator pin
    // ************************************************************
    // Once ready, crystal always drives clock out; else the enable bit decides
    assign drvClk = oscReady &&
                    ((usePri && priSel == `OSC_PRI_XTAL) ||
                     modeCfg_r[`OSC_CLOCK_OUTPUT_BIT]);

    // Half rate of the running source clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divToggle_r <= 1'b0;
        end else if (ce && drvClk) begin
            if (!usePri || oscRise) begin
                divToggle_r <= ~divToggle_r;
            end
        end
    end

    assign oscOutPinO  = drvClk ? divToggle_r : gpioOut;
    assign oscOutPinOe = drvClk | gpioOe;
    assign gpioIn      = oscOutSync;

    // ************************************************************
    // Sleep control
    // ************************************************************
    // Wake wins over a same-cycle software set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleepReq_r <= 1'b0;
        end else if (ce) begin
            if (wakeEvent) begin
                sleepReq_r <= 1'b0;
            end else if (doWrite && awAddr_r == `OSC_ADDR_CTRL &&
                         wStrb_r[0]) begin
                sleepReq_r <= wData_r[0];
            end
        end
    end

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    assign awready = ce & ~awHeld_r & ~bvalid;
    assign wready  = ce & ~wHeld_r & ~bvalid;
    assign doWrite = awHeld_r & wHeld_r & ~bvalid;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
        end else if (ce) begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= {awaddr[7:2], 2'h0};
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wHeld_r <= 1'b0;
            wData_r <= 32'h0;
            wStrb_r <= 4'h0;
        end else if (ce) begin
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= `OSC_RESP_OKAY;
        end else if (ce) begin
            if (doWrite) begin
                bvalid <= 1'b1;
                case (awAddr_r)
                    `OSC_ADDR_CTRL: bresp <= `OSC_RESP_OKAY;
                    `OSC_ADDR_SEL,
                    `OSC_ADDR_MODE,
                    `OSC_ADDR_STAT: bresp <= `OSC_RESP_SLVERR;
                    default:        bresp <= `OSC_RESP_DECERR;
                endcase
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    assign statWord = {12'h000, ostCount, 1'b0, sleepReq_r, drvClk,
                       ostRunning, pllLock, oscReady, src_r};

    assign arready = ce & ~rvalid;
    assign arTake  = arvalid & arready;

    always_comb begin
        rrNxt = `OSC_RESP_OKAY;
        case ({araddr[7:2], 2'h0})
            `OSC_ADDR_SEL:  rdNxt = {8'h00, selCfg_r};
            `OSC_ADDR_MODE: rdNxt = {8'h00, modeCfg_r};
            `OSC_ADDR_STAT: rdNxt = statWord;
            `OSC_ADDR_CTRL: rdNxt = {31'h0, sleepReq_r};
            default: begin
                rdNxt = 32'h0;
                rrNxt = `OSC_RESP_DECERR;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= `OSC_RESP_OKAY;
        end else if (ce) begin
            if (arTake) begin
                rvalid <= 1'b1;
                rdata  <= rdNxt;
                rresp  <= rrNxt;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule

// *** rtl/osc_params.svh ***
// Constants of the oscillator source configuration block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

// ********
// Register byte offsets
// ********
`define OSC_ADDR_SEL        8'h00
`define OSC_ADDR_MODE       8'h04
`define OSC_ADDR_STAT       8'h08
`define OSC_ADDR_CTRL       8'h0c

// ********
// Configuration word layout
// ********
`define OSC_SEL_MASK        24'h000003
`define OSC_MODE_MASK       24'h0000eb
`define OSC_GRP_LSB         0
`define OSC_PRI_LSB         0
`define OSC_CLOCK_OUTPUT_BIT        3
`define OSC_RANGE_BIT       5
`define OSC_SWMON_LSB       6
`define OSC_CFG_RESET       24'h000000

// ********
// Field encodings
// ********
`define OSC_PRI_EXT         2'h0
`define OSC_PRI_XTAL        2'h2

// ********
// Timing and fixed values
// ********
`define OSC_OST_W           10
`define OSC_OST_LAST        10'h3ff
`define OSC_PLL_MULT        6'h20
`define OSC_FRC_LO_KHZ      16'h25e4
`define OSC_FRC_HI_KHZ      16'h38d6

// ********
// Bus responses
// ********
`define OSC_RESP_OKAY       2'h0
`define OSC_RESP_SLVERR     2'h2
`define OSC_RESP_DECERR     2'h3

`endif

// *** rtl/osc_pkg.sv ***
// Types shared by the oscillator source configuration block.
// Assumes no other package.
package osc_pkg;

    // Selected clock source, one-hot
    typedef enum logic [3:0] {
        OSC_SRC_FRC     = 4'h1,
        OSC_SRC_FRC_PLL = 4'h2,
        OSC_SRC_PRI     = 4'h4,
        OSC_SRC_PRI_PLL = 4'h8
    } osc_src_e;

    // Start-up sequencer, one-hot
    typedef enum logic [4:0] {
        OSC_ST_POR   = 5'h01,
        OSC_ST_START = 5'h02,
        OSC_ST_OST   = 5'h04,
        OSC_ST_RUN   = 5'h08,
        OSC_ST_SLEEP = 5'h10
    } osc_state_e;

endpackage

// *** rtl/osc_startup_timer.sv ***
// Oscillator start-up timer: counts oscillator edges after a restart.
// Assumes oscRise is a one-cycle pulse per synchronised oscillator edge.
`timescale 1ns/1ps
`include "osc_params.svh"

module osc_startup_timer (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Control
    input  wire logic                  start,
    input  wire logic                  oscRise,
    // Status
    output logic                       running,
    output logic                       done,
    output logic [`OSC_OST_W-1:0]      count
);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count   <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else if (ce) begin
            if (start) begin
                count   <= '0;
                running <= 1'b1;
                done    <= 1'b0;
            end else if (running && oscRise) begin
                count <= count + 1'b1;
                if (count == `OSC_OST_LAST) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end
            end
        end
    end

endmodule

// *** rtl/osc_sync2.sv ***
// Two-stage synchroniser for asynchronous pin and analog inputs.
// Assumes the destination clock is clk.
`timescale 1ns/1ps

module osc_sync2 (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Asynchronous in, synchronous out
    input  wire logic [2:0] asyncIn,
    output logic      [2:0] syncOut
);

    logic [2:0] stage1_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1_r <= 3'h0;
            syncOut  <= 3'h0;
        end else if (ce) begin
            stage1_r <= asyncIn;
            syncOut  <= stage1_r;
        end
    end

endmodule

// *** testbench/osc_cfg_assertions.sv ***
// Concurrent checks on the oscillator source configuration top.
// Assumes binding to osc_cfg_top; sees its ports only.
`timescale 1ns/1ps
`include "osc_params.svh"

module osc_cfg_assertions (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Pins and lock
    input wire logic        oscInPinI,
    input wire logic        pllLockRaw,
    input wire logic        gpioOe,
    input wire logic        oscOutPinOe,
    // Control outputs
    input wire logic [3:0]  clkSel,
    input wire logic        feedbackEn,
    input wire logic        oscInHiZ,
    input wire logic        pllEnable,
    input wire logic [5:0]  pllMult,
    input wire logic        pllRangeHigh,
    input wire logic        frcRangeHigh,
    input wire logic [15:0] frcNominalKhz,
    input wire logic        clkSwitchEn,
    input wire logic        failMonEn,
    input wire logic        oscReady,
    input wire logic        pllLock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [10:0] riseCnt_r;
    logic [2:0]  sinceRst_r;
    logic        oscPrev_r;

    always_ff @(posedge clk) begin
        oscPrev_r <= oscInPinI;
    end
    // Sampled oscillator rises while the crystal starts
    always_ff @(posedge clk) begin
        if (!rst_n || !feedbackEn || oscReady)
            riseCnt_r <= 11'h000;
        else if (oscInPinI && !oscPrev_r && riseCnt_r != 11'h7ff)
            riseCnt_r <= riseCnt_r + 11'h001;
    end
    always_ff @(posedge clk) begin
        if (!rst_n)
            sinceRst_r <= 3'h0;
        else if (sinceRst_r != 3'h7)
            sinceRst_r <= sinceRst_r + 3'h1;
    end

    property p_sel_onehot; $onehot(clkSel); endproperty
    property p_monitor; failMonEn |-> clkSwitchEn; endproperty
    property p_range;
        frcRangeHigh == pllRangeHigh && frcNominalKhz ==
            (frcRangeHigh ? `OSC_FRC_HI_KHZ : `OSC_FRC_LO_KHZ);
    endproperty
    property p_no_clk_early; !oscReady |-> oscOutPinOe == gpioOe; endproperty
    property p_held;
        sinceRst_r == 3'h7 |->
            $stable({clkSel, clkSwitchEn, failMonEn, frcRangeHigh});
    endproperty
    // One edge of slack for the synchroniser
    property p_ost;
        $rose(oscReady) && feedbackEn |-> riseCnt_r >= 11'd1023;
    endproperty
    property p_mult; pllMult == `OSC_PLL_MULT; endproperty
    property p_lock_gate; pllLock |-> pllEnable && oscReady; endproperty
    property p_lock_loss; $fell(pllLockRaw) |-> ##[1:4] !pllLock; endproperty
    property p_lock_rise;
        (pllEnable && pllLockRaw) [*4] |-> pllLock;
    endproperty
    property p_hiz;
        feedbackEn |-> !oscInHiZ && (clkSel[2] || clkSel[3]);
    endproperty
    property p_pll_en; pllEnable |-> clkSel[1] || clkSel[3]; endproperty

    a_sel_onehot: assert property (p_sel_onehot) else $error("bad source");
    a_monitor: assert property (p_monitor) else $error("monitor alone");
    a_range: assert property (p_range) else $error("range mismatch");
    a_no_clk_early: assert property (p_no_clk_early) else $error("early");
    a_held: assert property (p_held) else $error("config moved");
    a_ost: assert property (p_ost) else $error("timer short");
    a_mult: assert property (p_mult) else $error("bad multiplier");
    a_lock_gate: assert property (p_lock_gate) else $error("stray lock");
    a_lock_loss: assert property (p_lock_loss) else $error("lock kept");
    a_lock_rise: assert property (p_lock_rise) else $error("no lock");
    a_hiz: assert property (p_hiz) else $error("feedback vs hi-z");
    a_pll_en: assert property (p_pll_en) else $error("pll on wrong");

    c_ost: cover property ($rose(oscReady) && feedbackEn);
    c_lock: cover property ($rose(pllLock));
    c_unlock: cover property ($fell(pllLock));
endmodule

bind osc_cfg_top osc_cfg_assertions u_chk (.*);

// *** testbench/osc_ext_src.sv ***
// Model of the external clock source and the analog PLL lock detector.
// Assumes the bench starts the clock; times are in ns.
`timescale 1ns/1ps

module osc_ext_src #(
    parameter real HALF_NS = 137.0,
    parameter real LOCK_NS = 400.0
) (
    // Control
    input  wire logic run,
    input  wire logic lockReq,
    input  wire logic lockDrop,
    // To the block
    output logic      clkOut,
    output logic      lockOut
);
    logic locked;

    // CMOS clock, low while stopped
    initial begin
        clkOut = 1'b0;
        forever begin
            if (run) #(HALF_NS) clkOut = ~clkOut;
            else begin
                clkOut = 1'b0;
                @(run);
            end
        end
    end
    // Lock after settling, lost at once
    initial begin
        locked = 1'b0;
        forever begin
            @(posedge lockReq);
            #(LOCK_NS) locked = lockReq;
            if (locked) @(negedge lockReq);
            locked = 1'b0;
        end
    end
    assign lockOut = locked && !lockDrop;
endmodule

// *** testbench/oscillator_source_config_tb.sv ***
// Self-checking bench for the oscillator source configuration block.
// Assumes osc_cfg_top, osc_ext_src and the bound checker are compiled.
`timescale 1ns/1ps

module oscillator_source_config_tb;
    logic        clk, rst_n, ce, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, clkSel;
    logic [1:0]  bresp, rresp;
    logic [23:0] cfgSelWord, cfgModeWord;
    logic        wakeEvent, oscInPinI, pllLockRaw, oscOutPinI, oscOutPinO;
    logic        oscOutPinOe, gpioOut, gpioOe, gpioIn, feedbackEn, oscInHiZ;
    logic        pllEnable, pllRangeHigh, frcRangeHigh, clkSwitchEn;
    logic        failMonEn, oscReady, pllLock, oscRun, lockDrop;
    logic [5:0]  pllMult;
    logic [15:0] frcNominalKhz;
    int          failures, samples_checked, oscRises, outToggles;

    osc_cfg_top u_dut (.*);
    osc_ext_src u_src (.run(oscRun), .lockReq(pllEnable),
        .lockDrop(lockDrop), .clkOut(oscInPinI), .lockOut(pllLockRaw));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge oscInPinI) oscRises++;
    always @(oscOutPinO) outToggles++;

    // ********
    // Shared tasks
    // ********
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic time_out();
        failures++;
        complete_run();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                break;
            end
        end
        bready <= 1'b0;
        if (n == 50) time_out();
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
        rready <= 1'b0;
        if (n == 50) time_out();
    endtask
    task automatic restart(input logic [23:0] s, input logic [23:0] m);
        rst_n <= 1'b0;
        cfgSelWord <= s;
        cfgModeWord <= m;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        oscRises = 0;
        @(posedge clk);
    endtask
    task automatic wait_ready(input int lim);
        int n;
        for (n = 0; n < lim && oscReady !== 1'b1; n++) @(posedge clk);
        if (n == lim) time_out();
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_groups();
        logic [7:0]  modes [4] = '{8'h0b, 8'h63, 8'h88, 8'he0};
        logic [3:0]  srcs [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++) begin
            restart({22'h3fffff, i[1:0]}, {16'hffff, modes[i]});
            wait_ready(20);
            check(clkSel, srcs[i]);
            check({clkSwitchEn, failMonEn},
                  {~modes[i][7], modes[i][7:6] == 2'b00});
            check(frcNominalKhz, modes[i][5] ? 16'h38d6 : 16'h25e4);
            check(pllMult, 6'h20);
            check(oscOutPinOe, modes[i][3]);
            check(oscInHiZ, 1'b1);
            axi_read(8'h00, d, r);
            check(d, {30'h0, i[1:0]});
            axi_read(8'h04, d, r);
            check(d, {24'h0, modes[i] & 8'heb});
            repeat (20) @(posedge clk);
            axi_read(8'h08, d, r);
            check(d[5:0], {i[0], 1'b1, srcs[i]});
            if (i == 2) begin
                oscRises = 0;
                outToggles = 0;
                repeat (100) @(posedge clk);
                check(outToggles + 1 >= oscRises &&
                      outToggles <= oscRises + 1, 1'b1);
            end
            if (i == 3) begin
                gpioOe <= 1'b1;
                gpioOut <= 1'b1;
                lockDrop <= 1'b1;
                oscOutPinI <= 1'b1;
                repeat (6) @(posedge clk);
                check({oscOutPinOe, oscOutPinO, pllLock, gpioIn}, 4'hd);
                axi_read(8'h08, d, r);
                check(d[5], 1'b0);
                gpioOe <= 1'b0;
                oscOutPinI <= 1'b0;
                lockDrop <= 1'b0;
            end
        end
    endtask
    task automatic t_crystal();
        logic [31:0] d;
        logic [1:0]  r;
        restart(24'h000002, 24'h000002);
        wait_ready(8000);
        check(oscRises >= 1024 && oscRises <= 1026, 1'b1);
        check({feedbackEn, oscInHiZ, oscOutPinOe}, 3'b101);
        axi_write(8'h0c, 32'h1, r);
        repeat (3) @(posedge clk);
        check({oscReady, feedbackEn}, 2'b00);
        oscRises = 0;
        wakeEvent <= 1'b1;
        @(posedge clk);
        wakeEvent <= 1'b0;
        wait_ready(8000);
        check(oscRises >= 1024 && oscRises <= 1027, 1'b1);
        axi_write(8'h00, 32'hffffffff, r);
        check(r, 2'h2);
        axi_read(8'h00, d, r);
        check(d, 32'h2);
        axi_write(8'h40, 32'h1, r);
        check(r, 2'h3);
        axi_read(8'h40, d, r);
        check({r, d[29:0]}, 32'hc0000000);
    endtask

    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {wakeEvent, oscOutPinI, gpioOut, gpioOe, lockDrop} = '0;
        {awaddr, araddr, wdata} = '0;
        {cfgSelWord, cfgModeWord} = '0;
        ce = 1'b1;
        wstrb = 4'hf;
        oscRun = 1'b1;
        failures = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        t_groups();
        t_crystal();
        complete_run();
    end
endmodule
